/* File: design/rccr_defs.vh */
/*
 * Register offsets, field positions and reset values of the rendering core
 * configuration bank. Assumes inclusion by the bank module and its bench.
 */
`ifndef RCCR_DEFS_VH
`define RCCR_DEFS_VH
// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define RCCR_SAMP_OFS   32'h005f8080
`define RCCR_PERP_OFS   32'h005f8084
`define RCCR_BGD_OFS    32'h005f8088
`define RCCR_BGT_OFS    32'h005f808c
`define RCCR_FEED_OFS   32'h005f8098
`define RCCR_REFR_OFS   32'h005f80a0
`define RCCR_ARB_OFS    32'h005f80a4
// ----------------------------------------------------------------------------
// Write masks (reserved bits clear)
// ----------------------------------------------------------------------------
`define RCCR_SAMP_MASK  32'h00000007
`define RCCR_PERP_MASK  32'h7fffffff
`define RCCR_BGD_MASK   32'hfffffff0
`define RCCR_BGT_MASK   32'h1fffffff
`define RCCR_FEED_MASK  32'h00fffff9
`define RCCR_REFR_MASK  32'h000000ff
`define RCCR_ARB_MASK   32'h003fffff
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RCCR_SAMP_RST   32'h00000007
`define RCCR_PERP_RST   32'h00000000
`define RCCR_BGD_RST    32'h00000000
`define RCCR_BGT_RST    32'h00000000
`define RCCR_FEED_RST   32'h00402000
`define RCCR_REFR_RST   32'h00000020
`define RCCR_ARB_RST    32'h0000001f
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCCR_BGT_BYPASS 28
`define RCCR_BGT_SHADOW 27
`define RCCR_BGT_SKIP_H 26
`define RCCR_BGT_SKIP_L 24
`define RCCR_BGT_ADR_H  23
`define RCCR_BGT_ADR_L  3
`define RCCR_BGT_OFF_H  2
`define RCCR_BGT_OFF_L  0
`define RCCR_FEED_TR_H  23
`define RCCR_FEED_TR_L  14
`define RCCR_FEED_PT_H  13
`define RCCR_FEED_PT_L  4
`define RCCR_FEED_DISC  3
`define RCCR_FEED_PRES  0
`define RCCR_ARB_OVR_H  21
`define RCCR_ARB_OVR_L  18
`define RCCR_ARB_MOD_H  17
`define RCCR_ARB_MOD_L  16
`define RCCR_ARB_CRT_H  15
`define RCCR_ARB_CRT_L  8
`define RCCR_ARB_LAT_H  7
`define RCCR_ARB_LAT_L  0
// ----------------------------------------------------------------------------
// Timing and codes
// ----------------------------------------------------------------------------
`define RCCR_REFR_UNIT  48
`define RCCR_VTX_BASE   3
`define RCCR_NREQ       11
`define RCCR_MODE_PRIO  2'h0
`define RCCR_MODE_OVR   2'h1
`endif

/* File: design/rccr_bank.v */
/*
 * Configuration register bank of the rendering core, with the refresh timer
 * and texture memory arbiter that its fields steer.
 * Assumes an APB master on clk; requester inputs and pass strobes come from
 * logic on the same clock.
 */
`include "rccr_defs.vh"

module rccr_bank #(
  parameter NREQ = `RCCR_NREQ
) (
  // Clock and reset
  input  wire            clk,
  input  wire            rst_b,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [31:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Pass control and context
  input  wire            pass_start,
  input  wire            region_hdr_type2,
  input  wire            select_volume_mode,
  input  wire [31:0]     parameter_base_address,
  // Latched pass configuration
  output reg  [2:0]      sample_half,
  output reg  [30:0]     perp_threshold,
  output reg  [31:0]     bg_depth,
  output reg             bg_cache_bypass,
  output reg             bg_shadow,
  output reg  [4:0]      bg_vertex_words,
  output reg  [31:0]     bg_fetch_addr,
  output reg  [2:0]      bg_strip_pos,
  output reg  [9:0]      trans_cache_vtx,
  output reg  [9:0]      punch_chunk_vtx,
  output reg             discard_en,
  output reg             presort_en,
  // Texture memory refresh
  output reg             refresh_req,
  // Texture memory arbiter
  input  wire [NREQ-1:0] mem_req,
  output reg  [NREQ-1:0] mem_grant,
  output reg             page_break
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [31:0] samp_reg;
  reg  [31:0] perp_reg;
  reg  [31:0] bgd_reg;
  reg  [31:0] bgt_reg;
  reg  [31:0] feed_reg;
  reg  [31:0] refr_reg;
  reg  [31:0] arb_reg;
  reg  [13:0] refr_cnt_reg;
  reg  [7:0]  own_cnt_reg;
  reg  [3:0]  rr_reg;
  reg  [31:0] rdata_next;
  reg         hit_next;

  wire        apb_acc = psel & penable & pready;
  wire        apb_wr  = apb_acc & pwrite;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Vertex size in words from skip field
  // Doubled skip reaches 17 words, hence five bits
  function [4:0] vtx_words;
    input [2:0] skip;
    input       dbl;
    begin
      if (dbl)
        vtx_words = {1'b0, skip, 1'b0} + 5'd`RCCR_VTX_BASE;
      else
        vtx_words = {2'b00, skip} + 5'd`RCCR_VTX_BASE;
    end
  endfunction

  // One-hot grant; bit i answers to override code i+1
  function [NREQ-1:0] pick;
    input [NREQ-1:0] req;
    input [1:0]      mode;
    input [3:0]      ovr;
    input [3:0]      rr;
    integer          i;
    reg              done;
    begin
      pick = {NREQ{1'b0}};
      done = 1'b0;
      for (i = 0; i < NREQ; i = i + 1) begin
        if (mode == `RCCR_MODE_OVR && ovr == i + 1 && req[i]) begin
          pick[i] = 1'b1;
          done = 1'b1;
        end
        if (mode[1] && rr == i + 1 && req[i]) begin
          pick[i] = 1'b1;
          done = 1'b1;
        end
      end
      for (i = 0; i < NREQ; i = i + 1) begin
        if (!done && req[i]) begin
          pick = {NREQ{1'b0}};
          pick[i] = 1'b1;
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // APB read decode
  // --------------------------------------------------------------------------
  always @* begin
    hit_next   = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
      `RCCR_SAMP_OFS: rdata_next = samp_reg;
      `RCCR_PERP_OFS: rdata_next = perp_reg;
      `RCCR_BGD_OFS:  rdata_next = bgd_reg;
      `RCCR_BGT_OFS:  rdata_next = bgt_reg;
      `RCCR_FEED_OFS: rdata_next = feed_reg;
      `RCCR_REFR_OFS: rdata_next = refr_reg;
      `RCCR_ARB_OFS:  rdata_next = arb_reg;
      default:        hit_next   = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // APB handshake: one wait state per access
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_next;
    end
  end

  // Read data held until the next read
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (psel & penable & ~pready & ~pwrite) begin
      prdata <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Address match of one register
  function is_at;
    input [31:0] addr;
    input [31:0] ofs;
    begin
      is_at = (addr == ofs);
    end
  endfunction

  // Write strobes, one per register
  wire        wr_samp = apb_wr & is_at(paddr, `RCCR_SAMP_OFS);
  wire        wr_perp = apb_wr & is_at(paddr, `RCCR_PERP_OFS);
  wire        wr_bgd  = apb_wr & is_at(paddr, `RCCR_BGD_OFS);
  wire        wr_bgt  = apb_wr & is_at(paddr, `RCCR_BGT_OFS);
  wire        wr_feed = apb_wr & is_at(paddr, `RCCR_FEED_OFS);
  wire        wr_refr = apb_wr & is_at(paddr, `RCCR_REFR_OFS);
  wire        wr_arb  = apb_wr & is_at(paddr, `RCCR_ARB_OFS);

  // Reserved bits masked on every write
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_reg <= `RCCR_SAMP_RST;
    end else if (wr_samp) begin
      samp_reg <= pwdata & `RCCR_SAMP_MASK;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      perp_reg <= `RCCR_PERP_RST;
    end else if (wr_perp) begin
      perp_reg <= pwdata & `RCCR_PERP_MASK;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bgd_reg <= `RCCR_BGD_RST;
    end else if (wr_bgd) begin
      bgd_reg <= pwdata & `RCCR_BGD_MASK;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bgt_reg <= `RCCR_BGT_RST;
    end else if (wr_bgt) begin
      bgt_reg <= pwdata & `RCCR_BGT_MASK;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feed_reg <= `RCCR_FEED_RST;
    end else if (wr_feed) begin
      feed_reg <= pwdata & `RCCR_FEED_MASK;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refr_reg <= `RCCR_REFR_RST;
    end else if (wr_refr) begin
      refr_reg <= pwdata & `RCCR_REFR_MASK;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arb_reg <= `RCCR_ARB_RST;
    end else if (wr_arb) begin
      arb_reg <= pwdata & `RCCR_ARB_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // Pass configuration, sampled at pass start
  // --------------------------------------------------------------------------
  // Sampling, compare and depth
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_half    <= 3'h7;
      perp_threshold <= 31'h00000000;
      bg_depth       <= 32'h00000000;
    end else if (pass_start) begin
      sample_half    <= samp_reg[2:0];
      perp_threshold <= perp_reg[30:0];
      bg_depth       <= bgd_reg;
    end
  end

  // Background tag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bg_cache_bypass <= 1'b0;
      bg_shadow       <= 1'b0;
      bg_vertex_words <= 5'h03;
      bg_fetch_addr   <= 32'h00000000;
      bg_strip_pos    <= 3'h0;
    end else if (pass_start) begin
      bg_cache_bypass <= bgt_reg[`RCCR_BGT_BYPASS];
      bg_shadow       <= bgt_reg[`RCCR_BGT_SHADOW];
      bg_vertex_words <= vtx_words(bgt_reg[`RCCR_BGT_SKIP_H:`RCCR_BGT_SKIP_L],
                                   select_volume_mode & bgt_reg[`RCCR_BGT_SHADOW]);
      bg_fetch_addr   <= parameter_base_address
                         + {9'h000, bgt_reg[`RCCR_BGT_ADR_H:`RCCR_BGT_ADR_L], 2'b00};
      bg_strip_pos    <= bgt_reg[`RCCR_BGT_OFF_H:`RCCR_BGT_OFF_L];
    end
  end

  // Sort cache and modes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trans_cache_vtx <= 10'h100;
      punch_chunk_vtx <= 10'h200;
      discard_en      <= 1'b0;
      presort_en      <= 1'b0;
    end else if (pass_start) begin
      trans_cache_vtx <= feed_reg[`RCCR_FEED_TR_H:`RCCR_FEED_TR_L];
      punch_chunk_vtx <= feed_reg[`RCCR_FEED_PT_H:`RCCR_FEED_PT_L];
      discard_en      <= feed_reg[`RCCR_FEED_DISC];
      presort_en      <= feed_reg[`RCCR_FEED_PRES] & ~region_hdr_type2;
    end
  end

  // --------------------------------------------------------------------------
  // Refresh timer
  // --------------------------------------------------------------------------
  wire [13:0] refr_span = refr_reg[7:0] * 6'd`RCCR_REFR_UNIT;
  wire        refr_hit  = (refr_cnt_reg + 14'd1 >= refr_span);

  // Period follows a new value on the fly
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refr_cnt_reg <= 14'h0000;
    end else begin
      refr_cnt_reg <= refr_hit ? 14'h0000 : refr_cnt_reg + 14'd1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_req <= 1'b0;
    end else begin
      refresh_req <= refr_hit;
    end
  end

  // --------------------------------------------------------------------------
  // Texture memory arbiter
  // --------------------------------------------------------------------------
  wire [3:0]  ovr_code = arb_reg[`RCCR_ARB_OVR_H:`RCCR_ARB_OVR_L];
  wire [1:0]  arb_mode = arb_reg[`RCCR_ARB_MOD_H:`RCCR_ARB_MOD_L];
  wire        own_crt  = mem_grant[NREQ-1];
  wire [7:0]  own_lim  = own_crt ? arb_reg[`RCCR_ARB_CRT_H:`RCCR_ARB_CRT_L]
                                 : arb_reg[`RCCR_ARB_LAT_H:`RCCR_ARB_LAT_L];
  wire        owner_on = |(mem_grant & mem_req);
  wire        others   = |(mem_req & ~mem_grant);
  wire        brk      = owner_on & others & (own_cnt_reg >= own_lim);
  wire        rearb    = ~owner_on | brk;

  // Grant and owner count; a zero latency re-arbitrates every cycle that another request waits behind a non-CRT owner
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_grant   <= {NREQ{1'b0}};
      own_cnt_reg <= 8'h00;
    end else if (rearb) begin
      mem_grant   <= pick(mem_req, arb_mode, ovr_code, rr_reg);
      own_cnt_reg <= 8'h00;
    end else if (own_cnt_reg != 8'hff) begin
      own_cnt_reg <= own_cnt_reg + 8'h01;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_break <= 1'b0;
    end else begin
      page_break <= brk;
    end
  end

  // Round-robin counter steps on each arbitration with a request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rr_reg <= 4'h1;
    end else if (rearb & (|mem_req)) begin
      rr_reg <= (rr_reg == NREQ) ? 4'h1 : rr_reg + 4'h1;
    end
  end

endmodule

/* File: dv/rccr_bank_monitor.sv */
/* Port checker of rccr_bank: bus answer, pass latching, arbiter.
   Assumes one clock domain and a bind onto rccr_bank. */
module rccr_bank_mon #(
  parameter NREQ = 11
) (
  // Clock and reset
  input wire            clk,
  input wire            rst_b,
  // Bus
  input wire            psel,
  input wire            penable,
  input wire            pready,
  input wire            pslverr,
  // Pass
  input wire            pass_start,
  input wire            region_hdr_type2,
  input wire            presort_en,
  input wire [2:0]      sample_half,
  input wire [31:0]     bg_fetch_addr,
  input wire [31:0]     bg_depth,
  // Arbiter
  input wire [NREQ-1:0] mem_req,
  input wire [NREQ-1:0] mem_grant,
  input wire            page_break
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  property p_ans; s_setup ##1 s_wait |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_hot; $onehot0(mem_grant); endproperty
  property p_own; mem_grant != 0 |-> (mem_grant & $past(mem_req)) != 0; endproperty
  property p_hold;
    !$past(pass_start) |-> $stable(sample_half) && $stable(bg_fetch_addr) && $stable(bg_depth);
  endproperty
  property p_pre; $past(pass_start) && $past(region_hdr_type2) |-> !presort_en; endproperty
  property p_dep; bg_depth[3:0] == 4'h0; endproperty
  property p_brk;
    page_break |-> $past(|(mem_grant & mem_req)) && $past(|(mem_req & ~mem_grant));
  endproperty
  a_ans: assert property (p_ans) else $error("late bus answer");
  a_one: assert property (p_one) else $error("ready too long");
  a_err: assert property (p_err) else $error("error without ready");
  a_hot: assert property (p_hot) else $error("grant not one-hot");
  a_own: assert property (p_own) else $error("grant without request");
  a_hold: assert property (p_hold) else $error("config moved between passes");
  a_pre: assert property (p_pre) else $error("pre-sort while type 2");
  a_dep: assert property (p_dep) else $error("depth low bits set");
  a_brk: assert property (p_brk) else $error("break without waiting request");
endmodule

bind rccr_bank rccr_bank_mon #(.NREQ(NREQ)) i_rccr_bank_mon (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .pass_start(pass_start), .region_hdr_type2(region_hdr_type2),
  .presort_en(presort_en), .sample_half(sample_half), .bg_fetch_addr(bg_fetch_addr),
  .bg_depth(bg_depth), .mem_req(mem_req), .mem_grant(mem_grant), .page_break(page_break)
);

/* File: dv/rccr_bank_tb.sv */
/* Self-checking bench of rccr_bank.
   Assumes the bank header on the include path and the bound checker. */
`include "rccr_defs.vh"
module rccr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pass_start = 0;
  logic region_hdr_type2 = 0, select_volume_mode = 0, pready, pslverr, er;
  logic [31:0] paddr = 0, pwdata = 0, parameter_base_address = 0, prdata, rd;
  logic [31:0] bg_depth, bg_fetch_addr;
  logic [30:0] perp_threshold;
  logic [2:0] sample_half, bg_strip_pos;
  logic [4:0] bg_vertex_words;
  logic [9:0] trans_cache_vtx, punch_chunk_vtx;
  logic bg_cache_bypass, bg_shadow, discard_en, presort_en, refresh_req, page_break;
  logic [10:0] mem_req = 0, mem_grant;
  int fails = 0, comparisons = 0;
  logic [31:0] ofs [7] = '{`RCCR_SAMP_OFS, `RCCR_PERP_OFS, `RCCR_BGD_OFS, `RCCR_BGT_OFS,
                           `RCCR_FEED_OFS, `RCCR_REFR_OFS, `RCCR_ARB_OFS};
  logic [31:0] rstv [7] = '{32'h7, 32'h0, 32'h0, 32'h0, 32'h00402000, 32'h20, 32'h1f};
  logic [31:0] msk [7] = '{32'h7, 32'h7fffffff, 32'hfffffff0, 32'h1fffffff,
                           32'h00fffff9, 32'hff, 32'h003fffff};
  rccr_bank i_rccr_bank (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pass_start(pass_start), .region_hdr_type2(region_hdr_type2),
    .select_volume_mode(select_volume_mode),
    .parameter_base_address(parameter_base_address), .sample_half(sample_half),
    .perp_threshold(perp_threshold), .bg_depth(bg_depth), .bg_cache_bypass(bg_cache_bypass),
    .bg_shadow(bg_shadow), .bg_vertex_words(bg_vertex_words), .bg_fetch_addr(bg_fetch_addr),
    .bg_strip_pos(bg_strip_pos), .trans_cache_vtx(trans_cache_vtx),
    .punch_chunk_vtx(punch_chunk_vtx), .discard_en(discard_en), .presort_en(presort_en),
    .refresh_req(refresh_req), .mem_req(mem_req), .mem_grant(mem_grant),
    .page_break(page_break));
  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      fails++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic pass();
    pass_start <= 1;
    @(posedge clk);
    pass_start <= 0;
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(0, ofs[i], 0);
      chk(rd, rstv[i]);
      apb(1, ofs[i], 32'hffffffff);
      apb(0, ofs[i], 0);
      chk(rd, msk[i]);
      apb(1, ofs[i], rstv[i]);
    end
    apb(1, 32'h005f8090, 32'hffffffff);
    chk(32'(er), 1);
    apb(0, 32'h005f8090, 0);
    chk(rd, 0);
    $display("t_regs done");
  endtask
  task automatic t_pass();
    parameter_base_address <= 32'h1000;
    select_volume_mode <= 1;
    apb(1, `RCCR_SAMP_OFS, 32'h2);
    apb(1, `RCCR_PERP_OFS, 32'h3f800000);
    apb(1, `RCCR_BGD_OFS, 32'h3f80000f);
    apb(1, `RCCR_BGT_OFS, 32'h1a00002b);
    apb(1, `RCCR_FEED_OFS, 32'h00168789);
    chk(32'(sample_half), 32'h7);
    pass();
    chk(32'(sample_half), 32'h2);
    chk(32'(perp_threshold), 32'h3f800000);
    chk(bg_depth, 32'h3f800000);
    chk(32'(bg_cache_bypass), 1);
    chk(32'(bg_shadow), 1);
    chk(32'(bg_vertex_words), 7);
    chk(bg_fetch_addr, 32'h1014);
    chk(32'(bg_strip_pos), 3);
    chk(32'(trans_cache_vtx), 32'h5a);
    chk(32'(punch_chunk_vtx), 32'h78);
    chk(32'(discard_en), 1);
    chk(32'(presort_en), 1);
    select_volume_mode <= 0;
    region_hdr_type2 <= 1;
    pass();
    chk(32'(bg_vertex_words), 5);
    chk(32'(presort_en), 0);
    $display("t_pass done");
  endtask
  task automatic gap(output int n);
    int k;
    k = 0;
    while (refresh_req !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (refresh_req !== 1'b1 && n < 300);
  endtask
  task automatic t_refr();
    int n;
    apb(1, `RCCR_REFR_OFS, 32'h1);
    gap(n);
    gap(n);
    chk(n, 48);
    apb(1, `RCCR_REFR_OFS, 32'h2);
    gap(n);
    gap(n);
    chk(n, 96);
    $display("t_refr done");
  endtask
  task automatic gr(input logic [10:0] req);
    mem_req <= req;
    repeat (3) @(posedge clk);
  endtask
  task automatic brk(input logic [31:0] cfg, input logic [10:0] req);
    int k;
    apb(1, `RCCR_ARB_OFS, cfg);
    gr(req);
    k = 0;
    while (page_break !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk(32'(page_break), 1);
    gr(0);
  endtask
  task automatic t_arb();
    for (int i = 0; i < 11; i++) begin
      gr(11'((32'h2 << i) - 1));
      chk(32'(mem_grant), 32'h1 << i);
      gr(0);
    end
    for (int k = 0; k < 16; k++) begin
      apb(1, `RCCR_ARB_OFS, (k << 18) | 32'h1001f);
      gr(11'h7ff);
      chk(32'(mem_grant), (k >= 1 && k <= 11) ? 32'h1 << (k - 1) : 32'h400);
      gr(0);
    end
    for (int m = 2; m < 4; m++) begin
      apb(1, `RCCR_ARB_OFS, (m << 16) | 32'h1f);
      gr(11'h7ff);
      chk(32'($onehot(mem_grant)), 1);
      gr(0);
    end
    brk(32'h2, 11'h021);
    brk(32'h31f, 11'h401);
    $display("t_arb done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    t_regs();
    t_pass();
    t_refr();
    t_arb();
    wrap_up();
  end
endmodule
